// file: src/crtsv_pkg.sv
// package: indices, field positions, resets, carriers
// assumes an indexed byte port and a single display clock
package crtsv_pkg;
  // register indices at the data port
  localparam logic [7:0] IDX_DSL = 8'h0D; // start low
  localparam logic [7:0] IDX_TCH = 8'h0E; // cursor high
  localparam logic [7:0] IDX_TCL = 8'h0F; // cursor low
  localparam logic [7:0] IDX_VSL = 8'h10; // sync start low
  localparam logic [7:0] IDX_VSE = 8'h11; // sync end, protect
  localparam logic [7:0] IDX_LOW_LAST = 8'h07; // top protected
  localparam logic [7:0] IDX_OVF = 8'h07; // overflow bits
  // field positions in the sync-end register
  localparam int PROT_BIT = 7; // write protect
  localparam int RFSH_BIT = 6; // no function
  localparam int VIE_BIT = 5; // compat only
  localparam int VIC_BIT = 4; // compat only
  localparam int VSE_END_MSB = 3; // end field top
  // field positions in the overflow register
  localparam int OVF_VSS9_BIT = 7;
  localparam int OVF_VSS8_BIT = 2;
  localparam int OVF_FREE_BIT = 4; // never protected
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] VSE_RESET = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [9:0] RST_VSS = 10'h000;
  localparam logic [3:0] RST_NIB = 4'h0;
  // one host access at the data port
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] index; // selected index
    logic [7:0] data; // write byte
  } crtsv_req_t;
  // write passed on to registers 00h..07h
  typedef struct packed {
    logic valid; // one-cycle pulse
    logic bit4_only; // only overflow bit 4 may change
    logic [2:0] index; // low index
    logic [7:0] data; // write byte
  } crtsv_fwd_t;
endpackage

// file: src/crtsv_regs.sv
// start address, cursor location and vertical sync registers
// assumes the index register and the other crt registers live elsewhere
`timescale 1ns/10ps
`default_nettype none
module crtsv_regs (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire crtsv_pkg::crtsv_req_t host_req,
  input  wire logic [7:0]            display_start_high,
  input  wire logic [7:0]            timing_overflow_bits,
  input  wire logic [9:0]            scan_line,
  input  wire logic                  line_stb,
  output logic [7:0]                 rd_data,
  output logic                       rd_ack,
  output crtsv_pkg::crtsv_fwd_t      low_wr,
  output logic                       protect,
  output logic [15:0]                start_offset,
  output logic [15:0]                cursor_offset,
  output logic [9:0]                 vsync_start,
  output logic [3:0]                 vsync_end,
  output logic                       vsync
);
  // stored registers
  logic [7:0]  dsl_reg;  // display_start_low
  logic [7:0]  dsl_next;
  logic [7:0]  tch_reg;  // text_cursor_loc_high
  logic [7:0]  tch_next;
  logic [7:0]  tcl_reg;  // text_cursor_loc_low
  logic [7:0]  tcl_next;
  logic [7:0]  vsl_reg;  // vsync_start_low
  logic [7:0]  vsl_next;
  logic [7:0]  vse_reg;  // vsync_end_protect
  logic [7:0]  vse_next;
  // derived outputs
  logic [15:0] sof_reg;  // start offset
  logic [15:0] sof_next;
  logic [15:0] cof_reg;  // cursor offset
  logic [15:0] cof_next;
  logic [9:0]  vss_reg;  // sync start
  logic [9:0]  vss_next;
  logic [3:0]  ven_reg;  // sync end field
  logic [3:0]  ven_next;
  logic        prot_reg; // protect copy
  logic        prot_next;
  // forwarded low writes
  crtsv_pkg::crtsv_fwd_t fwd_reg;
  crtsv_pkg::crtsv_fwd_t fwd_next;
  // read answer
  logic [7:0]  rdd_reg;
  logic [7:0]  rdd_next;
  logic        ack_reg;
  logic        ack_next;
  // decode helpers
  logic        wr_low;   // write aimed at 00h..07h
  logic        wr_ovf;   // write aimed at overflow

  // decode of protected range
  assign wr_low = host_req.wr && (host_req.index <= crtsv_pkg::IDX_LOW_LAST);
  assign wr_ovf = host_req.wr && (host_req.index == crtsv_pkg::IDX_OVF);

  // register writes
  always_comb begin
    dsl_next = dsl_reg;
    tch_next = tch_reg;
    tcl_next = tcl_reg;
    vsl_next = vsl_reg;
    vse_next = vse_reg;
    if (host_req.wr) begin
      case (host_req.index)
        crtsv_pkg::IDX_DSL: begin
          dsl_next = host_req.data;
        end
        crtsv_pkg::IDX_TCH: begin
          tch_next = host_req.data;
        end
        crtsv_pkg::IDX_TCL: begin
          tcl_next = host_req.data;
        end
        crtsv_pkg::IDX_VSL: begin
          vsl_next = host_req.data;
        end
        crtsv_pkg::IDX_VSE: begin
          // bits 6, 5, 4 only stored, no effect
          vse_next = host_req.data;
        end
        default: begin
          // other indices belong elsewhere
          dsl_next = dsl_reg;
        end
      endcase
    end
  end

  // stored registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dsl_reg <= crtsv_pkg::RST_BYTE;
      tch_reg <= crtsv_pkg::RST_BYTE;
      tcl_reg <= crtsv_pkg::RST_BYTE;
      vsl_reg <= crtsv_pkg::RST_BYTE;
      vse_reg <= crtsv_pkg::VSE_RESET;
    end else begin
      dsl_reg <= dsl_next;
      tch_reg <= tch_next;
      tcl_reg <= tcl_next;
      vsl_reg <= vsl_next;
      vse_reg <= vse_next;
    end
  end

  // offsets and sync values from the new contents
  always_comb begin
    sof_next = {display_start_high, dsl_next};
    cof_next = {tch_next, tcl_next};
    vss_next = {timing_overflow_bits[crtsv_pkg::OVF_VSS9_BIT],
                timing_overflow_bits[crtsv_pkg::OVF_VSS8_BIT],
                vsl_next};
    ven_next = vse_next[crtsv_pkg::VSE_END_MSB:0];
    prot_next = vse_next[crtsv_pkg::PROT_BIT];
  end

  // derived output registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sof_reg  <= crtsv_pkg::RST_WORD;
      cof_reg  <= crtsv_pkg::RST_WORD;
      vss_reg  <= crtsv_pkg::RST_VSS;
      ven_reg  <= crtsv_pkg::RST_NIB;
      prot_reg <= 1'b0;
    end else begin
      sof_reg  <= sof_next;
      cof_reg  <= cof_next;
      vss_reg  <= vss_next;
      ven_reg  <= ven_next;
      prot_reg <= prot_next;
    end
  end

  // low write gating by protect bit
  always_comb begin
    fwd_next = '0;
    if (wr_low && !vse_reg[crtsv_pkg::PROT_BIT]) begin
      fwd_next.valid = 1'b1;
      fwd_next.bit4_only = 1'b0;
    end else if (wr_ovf) begin
      // protected, but bit 4 still passes
      fwd_next.valid = 1'b1;
      fwd_next.bit4_only = 1'b1;
    end
    fwd_next.index = host_req.index[2:0];
    fwd_next.data = host_req.data;
    if (!fwd_next.valid) begin
      fwd_next.index = 3'h0;
      fwd_next.data = 8'h00;
    end
  end

  // forwarded write register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fwd_reg <= '0;
    end else begin
      fwd_reg <= fwd_next;
    end
  end

  // read mux for own indices
  always_comb begin
    rdd_next = 8'h00;
    ack_next = 1'b0;
    if (host_req.rd) begin
      ack_next = 1'b1;
      case (host_req.index)
        crtsv_pkg::IDX_DSL: begin
          rdd_next = dsl_reg;
        end
        crtsv_pkg::IDX_TCH: begin
          rdd_next = tch_reg;
        end
        crtsv_pkg::IDX_TCL: begin
          rdd_next = tcl_reg;
        end
        crtsv_pkg::IDX_VSL: begin
          rdd_next = vsl_reg;
        end
        crtsv_pkg::IDX_VSE: begin
          rdd_next = vse_reg;
        end
        default: begin
          // not ours: no answer
          ack_next = 1'b0;
        end
      endcase
    end
  end

  // read answer register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdd_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      rdd_reg <= rdd_next;
      ack_reg <= ack_next;
    end
  end

  // sync pulse from scan-line counter
  crtsv_vsync_gen u_vsync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .sync_start (vss_reg),
    .sync_end   (ven_reg),
    .scan_line  (scan_line),
    .line_stb   (line_stb),
    .vsync      (vsync)
  );

  // outputs straight from flops
  assign rd_data       = rdd_reg;
  assign rd_ack        = ack_reg;
  assign low_wr        = fwd_reg;
  assign protect       = prot_reg;
  assign start_offset  = sof_reg;
  assign cursor_offset = cof_reg;
  assign vsync_start   = vss_reg;
  assign vsync_end     = ven_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_prot_block;
    wr_low && vse_reg[crtsv_pkg::PROT_BIT] |=> !(fwd_reg.valid && !fwd_reg.bit4_only);
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("protected write passed");

  property p_low_pass;
    wr_low && !vse_reg[crtsv_pkg::PROT_BIT] |=>
      fwd_reg.valid && !fwd_reg.bit4_only && fwd_reg.data == $past(host_req.data);
  endproperty
  a_low_pass: assert property (p_low_pass) else $error("open write dropped");

  property p_ovf_free;
    wr_ovf |=> fwd_reg.valid && fwd_reg.index == 3'h7;
  endproperty
  a_ovf_free: assert property (p_ovf_free) else $error("overflow bit 4 write lost");

  property p_start_low;
    host_req.wr && host_req.index == crtsv_pkg::IDX_DSL |=>
      start_offset[7:0] == $past(host_req.data);
  endproperty
  a_start_low: assert property (p_start_low) else $error("start low wrong");

  property p_start_high;
    1'b1 |=> start_offset[15:8] == $past(display_start_high);
  endproperty
  a_start_high: assert property (p_start_high) else $error("start high wrong");

  property p_cur_high;
    host_req.wr && host_req.index == crtsv_pkg::IDX_TCH |=>
      cursor_offset[15:8] == $past(host_req.data);
  endproperty
  a_cur_high: assert property (p_cur_high) else $error("cursor high wrong");

  property p_cur_low;
    host_req.wr && host_req.index == crtsv_pkg::IDX_TCL |=>
      cursor_offset[7:0] == $past(host_req.data);
  endproperty
  a_cur_low: assert property (p_cur_low) else $error("cursor low wrong");

  property p_vss_top;
    1'b1 |=> vsync_start[9:8] == {$past(timing_overflow_bits[7]), $past(timing_overflow_bits[2])};
  endproperty
  a_vss_top: assert property (p_vss_top) else $error("sync start top bits wrong");

  property p_vse_back;
    host_req.wr && host_req.index == crtsv_pkg::IDX_VSE ##1
      host_req.rd && host_req.index == crtsv_pkg::IDX_VSE |=>
      rd_ack && rd_data == $past(host_req.data, 2);
  endproperty
  a_vse_back: assert property (p_vse_back) else $error("sync end readback wrong");

  c_prot_ovf: cover property (wr_ovf && vse_reg[crtsv_pkg::PROT_BIT]);
  c_prot_low: cover property (wr_low && vse_reg[crtsv_pkg::PROT_BIT]);
  c_rd_vse: cover property (host_req.rd && host_req.index == crtsv_pkg::IDX_VSE);
  c_vsync: cover property (vsync ##1 !vsync);
endmodule // crtsv_regs
`default_nettype wire

// file: src/crtsv_vsync_gen.sv
// vertical sync pulse generator
// assumes line_stb pulses once per line with scan_line holding the new line
`timescale 1ns/10ps
`default_nettype none
module crtsv_vsync_gen (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] sync_start,
  input  wire logic [3:0] sync_end,
  input  wire logic [9:0] scan_line,
  input  wire logic       line_stb,
  output logic            vsync
);
  logic vs_reg; // pulse state
  logic vs_next;

  // start on the matching line, end on low-nibble match
  always_comb begin
    vs_next = vs_reg;
    if (line_stb) begin
      if (!vs_reg && scan_line == sync_start) begin
        vs_next = 1'b1;
      end else if (vs_reg && scan_line[3:0] == sync_end) begin
        vs_next = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vs_reg <= 1'b0;
    end else begin
      vs_reg <= vs_next;
    end
  end

  assign vsync = vs_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_vs_begin;
    line_stb && !vs_reg && scan_line == sync_start |=> vs_reg;
  endproperty
  a_vs_begin: assert property (p_vs_begin) else $error("vsync did not begin");

  property p_vs_end;
    line_stb && vs_reg && scan_line[3:0] == sync_end |=> !vs_reg;
  endproperty
  a_vs_end: assert property (p_vs_end) else $error("vsync did not end");

  property p_vs_hold;
    !line_stb |=> $stable(vs_reg);
  endproperty
  a_vs_hold: assert property (p_vs_hold) else $error("vsync moved off line edge");

  c_vs_pulse: cover property (line_stb && vs_reg ##1 !vs_reg);
endmodule // crtsv_vsync_gen
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the start, cursor and vertical sync register block
// assumes the package and design files under src/ are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                  ref_clk;       // display clock
  logic                  rst_n;         // sync reset, low active
  crtsv_pkg::crtsv_req_t host_req;      // host access at the data port
  logic [7:0]            start_high;    // start high byte from the controller
  logic [7:0]            ovf;           // overflow register copy
  logic [9:0]            scan_line;     // current scan line
  logic                  line_stb;      // line start pulse
  logic [7:0]            rd_data;       // read byte
  logic                  rd_ack;        // read hit
  crtsv_pkg::crtsv_fwd_t low_wr;        // forwarded low write
  logic                  protect;       // protect copy
  logic [15:0]           start_offset;  // fetch start
  logic [15:0]           cursor_offset; // cursor place
  logic [9:0]            vsync_start;   // sync start line
  logic [3:0]            vsync_end;     // sync end nibble
  logic                  vsync;         // sync pulse
  int                    failures;      // mismatches seen
  int                    checks;        // comparisons made
  int                    cycles;        // timeout counter
  logic [7:0]            shadow [5];    // expected bytes of 0Dh..11h

  crtsv_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req), .display_start_high(start_high),
    .timing_overflow_bits(ovf), .scan_line(scan_line), .line_stb(line_stb), .rd_data(rd_data),
    .rd_ack(rd_ack), .low_wr(low_wr), .protect(protect), .start_offset(start_offset),
    .cursor_offset(cursor_offset), .vsync_start(vsync_start), .vsync_end(vsync_end), .vsync(vsync));

  // clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // step to just after the next rising edge
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask

  // compare one value, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // present one request for a single edge
  task automatic access(input logic w, input logic r, input logic [7:0] idx, input logic [7:0] d);
    host_req = '{wr: w, rd: r, index: idx, data: d};
    cyc();
  endtask

  // drop the strobes for one cycle
  task automatic idle();
    host_req = '0;
    cyc();
  endtask

  // expected read answer for an index
  function automatic logic [8:0] rd_exp(input logic [7:0] idx);
    if (idx >= 8'h0D && idx <= 8'h11) return {1'b1, shadow[idx - 8'h0D]};
    return 9'h000;
  endfunction

  // level outputs against the shadow copy
  task automatic chk_outs();
    chk(start_offset, {start_high, shadow[0]}, "start offset");
    chk(cursor_offset, {shadow[1], shadow[2]}, "cursor offset");
    chk(16'(vsync_start), {6'h00, ovf[7], ovf[2], shadow[3]}, "sync start");
    chk(16'(vsync_end), {12'h000, shadow[4][3:0]}, "sync end");
    chk(16'(protect), {15'h0000, shadow[4][7]}, "protect");
  endtask

  // write one byte, then check forwarding and outputs
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic prot;
    logic v;
    prot = shadow[4][7];
    v = (idx <= 8'h07) && (!prot || idx == 8'h07);
    access(1'b1, 1'b0, idx, d);
    if (idx >= 8'h0D && idx <= 8'h11) shadow[idx - 8'h0D] = d;
    chk(16'(low_wr), {3'h0, v, v & prot, v ? idx[2:0] : 3'h0, v ? d : 8'h00}, "low write");
    chk_outs();
  endtask

  // read one index and check the answer
  task automatic rreg(input logic [7:0] idx);
    access(1'b0, 1'b1, idx, 8'h00);
    chk(16'({rd_ack, rd_data}), 16'(rd_exp(idx)), "read back");
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [9:0] s;
    logic [9:0] l;
    logic [3:0] e;
    logic [7:0] d;
    logic ev;
    void'($urandom(32'hA676B9DE));
    host_req = '0;
    start_high = 8'h00;
    ovf = 8'h00;
    scan_line = 10'h000;
    line_stb = 1'b0;
    rst_n = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (16) cyc();
    rst_n = 1'b1;
    cyc();
    chk_outs();
    for (int i = 8'h0D; i <= 8'h12; i++) rreg(8'(i));
    idle();
    $display("test reset values done");
    // random writes and reads over low, mapped and unmapped indices
    repeat (60) begin
      start_high = 8'($urandom);
      ovf = 8'($urandom);
      idle();
      wreg(8'($urandom_range(0, 18)), 8'($urandom));
      rreg(8'($urandom_range(0, 20)));
      idle();
    end
    $display("test random access done");
    // protect on: low writes dropped, overflow still forwarded
    wreg(8'h11, 8'h80);
    wreg(8'h00, 8'h5A);
    wreg(8'h07, 8'hFF);
    wreg(8'h06, 8'h11);
    // cursor bytes stay writable while protect is on
    wreg(8'h0E, 8'hFF);
    wreg(8'h0F, 8'h00);
    // protect off with compat bits set: stored, read back at once
    wreg(8'h11, 8'h7C);
    rreg(8'h11);
    wreg(8'h07, 8'hA5);
    // write and read together: read sees the old byte
    d = shadow[0];
    access(1'b1, 1'b1, 8'h0D, 8'hC3);
    shadow[0] = 8'hC3;
    chk(16'({rd_ack, rd_data}), {7'h00, 1'b1, d}, "read during write");
    idle();
    chk_outs();
    $display("test protect and compat bits done");
    // sync pulse start and end over random positions
    repeat (6) begin
      s = 10'($urandom);
      e = 4'($urandom);
      ovf = 8'($urandom);
      ovf[7] = s[9];
      ovf[2] = s[8];
      idle();
      wreg(8'h10, s[7:0]);
      wreg(8'h11, {4'h0, e});
      idle();
      ev = 1'b0;
      line_stb = 1'b1;
      for (int k = -2; k <= 20; k++) begin
        l = s + 10'(k);
        scan_line = l;
        cyc();
        if (!ev && l == s) ev = 1'b1;
        else if (ev && l[3:0] == e) ev = 1'b0;
        chk(16'(vsync), {15'h0000, ev}, "vsync");
      end
      line_stb = 1'b0;
      cyc();
    end
    $display("test vertical sync done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
